// [rtl/axf_core.sv]
/*
 * auxiliary input result formatting, reference selection, threshold
 * encoding and input overvoltage protection, with an apb register slave.
 * assumes the converter delivers raw samples on pclk and that the
 * overvoltage detectors are asynchronous analogue comparator outputs.
 */
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - ratiometric result: 14-bit code, register shifted two
// - absolute result: same scale, low bits zero
// - ratio threshold 13-bit code, register shifted four, less eight if nonzero, fff0 at full scale
// - absolute threshold 10-bit code, register shifted six
// - per-port select picks reference for adc, comparator
// - above reference clamps at full scale
// - separate alert thresholds per measurement type
// - measure port only when its enable set
// - same result registers regardless of reference
// - overvoltage on a port not in general io disconnects input, sets protect flag
// - flag and disconnect held until config rewrite
// - summary flag is OR of six flags
// - bias switch: auto, off, on by mode
// - general io enable overrides measure enable
module axf_core #(
    parameter int NP = axf_pkg::NUM_PORTS
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // converter side
    input wire axf_pkg::axf_sample_t sample_in,
    input wire logic acq_active,
    input wire logic [NP-1:0] ov_detect_async,
    // analogue control
    output logic [NP-1:0] port_disconnect,
    output logic [NP-1:0] port_reference_select,
    output logic [NP-1:0] port_measure_active,
    output logic bias_supply_output,
    output logic [NP-1:0] port_ov_alert,
    output logic [NP-1:0] port_uv_alert
);
    // ****************************************************************
    // registers
    // ****************************************************************
    logic [NP-1:0] meas_en_reg;
    logic [NP-1:0] ref_sel_reg;
    logic [NP-1:0] gpio_en_reg;
    logic [1:0] bias_mode_reg;
    logic [12:0] ratio_ov_reg, ratio_uv_reg;
    logic [9:0] abs_ov_reg, abs_uv_reg;
    logic [NP-1:0] protect_reg;
    logic [NP-1:0] ov_meta_reg, ov_sync_reg;
    logic [15:0] result_reg [NP];
    logic [NP-1:0] ova_reg, uva_reg;

    // ****************************************************************
    // functions
    // ****************************************************************
    function automatic logic [15:0] ratio_th_enc(input logic [12:0] c);
        logic [12:0] k;
        k = (c > axf_pkg::RATIO_TH_FULL) ? axf_pkg::RATIO_TH_FULL : c;
        ratio_th_enc = (k == axf_pkg::RATIO_TH_FULL) ? 16'hfff0 :
            {k[11:0], 3'b000, 1'b0} - ((k == 13'h0000) ? 16'h0000 :
            16'h0008);
    endfunction : ratio_th_enc

    function automatic logic [15:0] abs_th_enc(input logic [9:0] c);
        abs_th_enc = {c, 6'h00};
    endfunction : abs_th_enc

    // ****************************************************************
    // decode
    // ****************************************************************
    wire logic acc = psel & penable;
    wire logic wr = acc & pwrite;
    wire logic [NP-1:0] meas_eff = meas_en_reg & ~gpio_en_reg;
    wire logic smp_ok = sample_in.valid && (sample_in.port < 3'(NP));
    wire logic [2:0] sp = sample_in.port;
    // saturate anything above the 14-bit full scale
    wire logic [13:0] clamped = (sample_in.code > 15'(axf_pkg::ADC_FULL))
        ? axf_pkg::ADC_FULL : sample_in.code[13:0];
    // one register format for both references
    wire logic [15:0] formatted = {clamped, 2'b00};
    wire logic hit_res = (paddr >= axf_pkg::OFF_RESULT0) &&
        (paddr < axf_pkg::OFF_RESULT0 + 8'(4 * NP)) && (paddr[1:0] == 2'b00);
    wire logic [2:0] res_idx = 3'((paddr - axf_pkg::OFF_RESULT0) >> 2);
    logic [31:0] rd_mux;
    logic rd_err;
    logic [15:0] th_ov, th_uv;

    always_comb begin
        rd_err = 1'b0;
        rd_mux = 32'h0000_0000;
        if (paddr == axf_pkg::OFF_MEASURE_EN) begin
            rd_mux = 32'(meas_en_reg);
        end else if (paddr == axf_pkg::OFF_REF_CTRL) begin
            rd_mux = 32'(ref_sel_reg);
        end else if (paddr == axf_pkg::OFF_PORT_CFG) begin
            rd_mux = 32'(gpio_en_reg);
        end else if (paddr == axf_pkg::OFF_BIAS_MODE) begin
            rd_mux = 32'(bias_mode_reg);
        end else if (paddr == axf_pkg::OFF_DIAG_TWO) begin
            rd_mux = {24'h000000, 1'b0, |protect_reg,
                6'(protect_reg)};
        end else if (paddr == axf_pkg::OFF_RATIO_OV) begin
            rd_mux = {16'h0000, ratio_th_enc(ratio_ov_reg)};
        end else if (paddr == axf_pkg::OFF_RATIO_UV) begin
            rd_mux = {16'h0000, ratio_th_enc(ratio_uv_reg)};
        end else if (paddr == axf_pkg::OFF_ABS_OV) begin
            rd_mux = {16'h0000, abs_th_enc(abs_ov_reg)};
        end else if (paddr == axf_pkg::OFF_ABS_UV) begin
            rd_mux = {16'h0000, abs_th_enc(abs_uv_reg)};
        end else if (paddr == axf_pkg::OFF_ALERT) begin
            rd_mux = {16'h0000, 2'b00, 6'(uva_reg), 2'b00, 6'(ova_reg)};
        end else if (hit_res) begin
            rd_mux = {16'h0000, result_reg[res_idx]};
        end else begin
            rd_err = 1'b1;
        end
    end

    // the sample's own reference picks its thresholds
    always_comb begin
        if (ref_sel_reg[sp]) begin
            th_ov = abs_th_enc(abs_ov_reg);
            th_uv = abs_th_enc(abs_uv_reg);
        end else begin
            th_ov = ratio_th_enc(ratio_ov_reg);
            th_uv = ratio_th_enc(ratio_uv_reg);
        end
    end

    wire logic cfg_wr = wr && (paddr == axf_pkg::OFF_PORT_CFG);
    // a port only takes samples when enabled and not protected
    wire logic [NP-1:0] take = NP'(smp_ok) << sp &
        meas_eff & ~protect_reg;
    wire logic bias_next = (bias_mode_reg == axf_pkg::BIAS_ON) ? 1'b1 :
        (bias_mode_reg == axf_pkg::BIAS_OFF) ? 1'b0 : acq_active;

    // ****************************************************************
    // apb and control
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meas_en_reg <= '0;
            ref_sel_reg <= '0;
            gpio_en_reg <= '0;
            bias_mode_reg <= axf_pkg::BIAS_MODE_RST;
            ratio_ov_reg <= axf_pkg::RATIO_TH_FULL;
            ratio_uv_reg <= 13'h0000;
            abs_ov_reg <= axf_pkg::ABS_TH_FULL;
            abs_uv_reg <= 10'h000;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            // one wait state: answer registered, then completes
            pready <= acc & ~pready;
            pslverr <= acc & ~pready & rd_err;
            prdata <= (acc & ~pready & ~pwrite) ? rd_mux : 32'h0000_0000;
            if (wr && pready) begin
                if (paddr == axf_pkg::OFF_MEASURE_EN) begin
                    meas_en_reg <= pwdata[NP-1:0];
                end else if (paddr == axf_pkg::OFF_REF_CTRL) begin
                    ref_sel_reg <= pwdata[NP-1:0];
                end else if (paddr == axf_pkg::OFF_PORT_CFG) begin
                    gpio_en_reg <= pwdata[NP-1:0];
                end else if (paddr == axf_pkg::OFF_BIAS_MODE) begin
                    bias_mode_reg <= pwdata[1:0];
                end else if (paddr == axf_pkg::OFF_RATIO_OV) begin
                    ratio_ov_reg <= pwdata[12:0];
                end else if (paddr == axf_pkg::OFF_RATIO_UV) begin
                    ratio_uv_reg <= pwdata[12:0];
                end else if (paddr == axf_pkg::OFF_ABS_OV) begin
                    abs_ov_reg <= pwdata[9:0];
                end else if (paddr == axf_pkg::OFF_ABS_UV) begin
                    abs_uv_reg <= pwdata[9:0];
                end
            end
        end
    end

    // ****************************************************************
    // protection
    // ****************************************************************
    // only ports in auxiliary use can trip; a trip in the clearing cycle
    // wins so a live overvoltage is never lost
    wire logic [NP-1:0] trip = ov_sync_reg & ~gpio_en_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ov_meta_reg <= '0;
            ov_sync_reg <= '0;
            protect_reg <= '0;
        end else begin
            ov_meta_reg <= ov_detect_async;
            ov_sync_reg <= ov_meta_reg;
            protect_reg <= ((cfg_wr && pready) ? '0 : protect_reg) | trip;
        end
    end

    // ****************************************************************
    // results and alerts
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NP; i++) begin
                result_reg[i] <= axf_pkg::RESULT_RST;
            end
            ova_reg <= '0;
            uva_reg <= '0;
        end else begin
            for (int i = 0; i < NP; i++) begin
                if (take[i]) begin
                    result_reg[i] <= formatted;
                    ova_reg[i] <= formatted > th_ov;
                    uva_reg[i] <= formatted < th_uv;
                end
            end
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_disconnect <= '0;
            port_reference_select <= '0;
            port_measure_active <= '0;
            bias_supply_output <= 1'b0;
            port_ov_alert <= '0;
            port_uv_alert <= '0;
        end else begin
            port_disconnect <= protect_reg | trip;
            port_reference_select <= ref_sel_reg;
            port_measure_active <= meas_eff & ~protect_reg;
            bias_supply_output <= bias_next;
            port_ov_alert <= ova_reg;
            port_uv_alert <= uva_reg;
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    property p_trip_sets;
        @(posedge pclk) disable iff (!presetn)
        trip != '0 |=> (protect_reg & $past(trip)) == $past(trip);
    endproperty
    a_trip_sets: assert property (p_trip_sets)
        else $error("flag missed");

    property p_hold;
        @(posedge pclk) disable iff (!presetn)
        !(cfg_wr && pready) && trip == '0 |=>
            protect_reg == $past(protect_reg);
    endproperty
    a_hold: assert property (p_hold) else $error("flag changed");

    property p_sum;
        @(posedge pclk) disable iff (!presetn)
        acc && !pready && !pwrite && paddr == axf_pkg::OFF_DIAG_TWO
        |=> prdata[6] == |$past(protect_reg);
    endproperty
    a_sum: assert property (p_sum) else $error("summary wrong");

    property p_fmt;
        @(posedge pclk) disable iff (!presetn)
        take[0] |=> result_reg[0][1:0] == 2'b00 &&
            result_reg[0][15:2] == $past(clamped);
    endproperty
    a_fmt: assert property (p_fmt) else $error("result form");

    property p_clamp;
        @(posedge pclk) disable iff (!presetn)
        take[0] && sample_in.code[14] |=> result_reg[0] == 16'hfffc;
    endproperty
    a_clamp: assert property (p_clamp) else $error("no clamp");

    property p_gate;
        @(posedge pclk) disable iff (!presetn)
        smp_ok && sp == 3'd2 && !meas_eff[2]
        |=> result_reg[2] == $past(result_reg[2]);
    endproperty
    a_gate: assert property (p_gate) else $error("gated write");

    property p_bias;
        @(posedge pclk) disable iff (!presetn)
        bias_mode_reg == axf_pkg::BIAS_OFF
            ##1 bias_mode_reg == axf_pkg::BIAS_OFF
        |-> !bias_supply_output;
    endproperty
    a_bias: assert property (p_bias) else $error("bias on");

    property p_ref;
        @(posedge pclk) disable iff (!presetn)
        1'b1 |=> port_reference_select == $past(ref_sel_reg);
    endproperty
    a_ref: assert property (p_ref) else $error("ref select");

    property p_disc;
        @(posedge pclk) disable iff (!presetn)
        ov_detect_async[4] ##1 ov_detect_async[4] && !gpio_en_reg[4]
            ##1 !gpio_en_reg[4] |=> ##1 port_disconnect[4];
    endproperty
    a_disc: assert property (p_disc) else $error("no disconnect");
endmodule : axf_core

`default_nettype wire

// [rtl/axf_pkg.sv]
/*
 * shared constants and carriers for the auxiliary input result formatter.
 * assumes a 32-bit apb master on pclk and six analogue ports.
 */
package axf_pkg;
    localparam int NUM_PORTS = 6;
    // register byte offsets
    localparam logic [7:0] OFF_MEASURE_EN = 8'h00;
    localparam logic [7:0] OFF_REF_CTRL = 8'h04;
    localparam logic [7:0] OFF_PORT_CFG = 8'h08;
    localparam logic [7:0] OFF_BIAS_MODE = 8'h0c;
    localparam logic [7:0] OFF_DIAG_TWO = 8'h10;
    localparam logic [7:0] OFF_RATIO_OV = 8'h14;
    localparam logic [7:0] OFF_RATIO_UV = 8'h18;
    localparam logic [7:0] OFF_ABS_OV = 8'h1c;
    localparam logic [7:0] OFF_ABS_UV = 8'h20;
    localparam logic [7:0] OFF_ALERT = 8'h24;
    localparam logic [7:0] OFF_RESULT0 = 8'h40;
    // code limits
    localparam logic [13:0] ADC_FULL = 14'h3fff;
    localparam logic [12:0] RATIO_TH_FULL = 13'h1000;
    localparam logic [9:0] ABS_TH_FULL = 10'h3ff;
    // bias switch modes
    localparam logic [1:0] BIAS_OFF = 2'b10;
    localparam logic [1:0] BIAS_ON = 2'b11;
    // reset values
    localparam logic [1:0] BIAS_MODE_RST = 2'b00;
    localparam logic [15:0] RESULT_RST = 16'h0000;

    typedef struct packed {
        logic valid;
        logic [2:0] port;
        logic [14:0] code;
    } axf_sample_t;
endpackage : axf_pkg

// [sim/axf_src_model.sv]
/*
 * far-side source model: converter samples, acquisition level and the
 * overvoltage detectors that stand in for the analogue port inputs.
 * assumes callers start each task just after a rising pclk edge.
 */
`timescale 1ns/1ps
`default_nettype none
module axf_src_model (
    // clock
    input wire logic pclk,
    // converter and detector side
    output var axf_pkg::axf_sample_t sample_in,
    output var logic acq_active,
    output var logic [5:0] ov_detect_async
);
    initial begin
        sample_in = '0;
        acq_active = 1'b0;
        ov_detect_async = '0;
    end
    // code is inverted after the pulse so a stale value never matches
    task automatic send(input logic [2:0] p, input logic [14:0] c);
        @(posedge pclk);
        sample_in <= '{valid: 1'b1, port: p, code: c};
        @(posedge pclk);
        sample_in.valid <= 1'b0;
        sample_in.code <= ~c;
    endtask : send
    task automatic set_ov(input logic [5:0] m);
        @(posedge pclk);
        ov_detect_async <= m;
    endtask : set_ov
    task automatic set_acq(input logic v);
        @(posedge pclk);
        acq_active <= v;
    endtask : set_acq
endmodule : axf_src_model
`default_nettype wire

// [sim/test_aux_input_result_format.sv]
/*
 * self-checking bench for the auxiliary result formatter: apb tasks,
 * source model for samples and detectors, one directed sequence.
 * assumes the package constants and the hand-over timing of the core.
 */
`timescale 1ns/1ps
`default_nettype none
module test_aux_input_result_format;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rd_err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd_data;
    axf_pkg::axf_sample_t smp;
    logic acq, bias;
    logic [5:0] ov_det, disc, ref_sel, meas, ov_al, uv_al;
    logic [31:0] tc [6] = '{32'h800, 32'h1000, 32'h0, 32'h200, 32'h3ff,
        32'h0};
    logic [31:0] te [6] = '{32'h7ff8, 32'hfff0, 32'h0, 32'h8000, 32'hffc0,
        32'h0};
    int error_cnt = 0;
    int check_count = 0;

    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    axf_core dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sample_in(smp), .acq_active(acq), .ov_detect_async(ov_det),
        .port_disconnect(disc), .port_reference_select(ref_sel),
        .port_measure_active(meas), .bias_supply_output(bias),
        .port_ov_alert(ov_al), .port_uv_alert(uv_al));
    axf_src_model src (.pclk(pclk), .sample_in(smp), .acq_active(acq),
        .ov_detect_async(ov_det));

    // ****************************************
    // checking and apb tasks
    // ****************************************
    task automatic end_of_test;
        $display("errors %0d checks %0d", error_cnt, check_count);
        if (error_cnt == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_of_test
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // holds the request until pready is sampled, then idles one cycle;
    // only the watchdog ends a wait that never completes
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd_data = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk("read data", e, rd_data);
    endtask : rd

    // ****************************************
    // directed sequence
    // ****************************************
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        presetn = 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(axf_pkg::OFF_RESULT0, 32'h0);
        rd(axf_pkg::OFF_RATIO_OV, 32'hfff0);
        rd(axf_pkg::OFF_ABS_OV, 32'hffc0);
        for (int i = 0; i < 6; i++) begin
            wr(i < 3 ? axf_pkg::OFF_RATIO_UV : axf_pkg::OFF_ABS_UV, tc[i]);
            rd(i < 3 ? axf_pkg::OFF_RATIO_UV : axf_pkg::OFF_ABS_UV,
                te[i]);
        end
        wr(axf_pkg::OFF_RATIO_OV, 32'h800);
        wr(axf_pkg::OFF_ABS_OV, 32'h3ff);
        // port 2 disabled, port 1 absolute, port 3 general io
        wr(axf_pkg::OFF_MEASURE_EN, 32'h1b);
        wr(axf_pkg::OFF_REF_CTRL, 32'h2);
        wr(axf_pkg::OFF_PORT_CFG, 32'h8);
        repeat (2) @(posedge pclk);
        chk("reference select", 32'h2, {26'h0, ref_sel});
        chk("measure active", 32'h13, {26'h0, meas});
        src.send(3'd0, 15'h2000);
        src.send(3'd1, 15'h2000);
        repeat (2) @(posedge pclk);
        chk("over alerts", 32'h1, {26'h0, ov_al});
        chk("under alerts", 32'h0, {26'h0, uv_al});
        rd(axf_pkg::OFF_RESULT0, 32'h8000);
        rd(axf_pkg::OFF_RESULT0 + 8'h04, 32'h8000);
        src.send(3'd0, 15'h7fff);
        src.send(3'd0, 15'h3fff);
        src.send(3'd1, 15'h4000);
        src.send(3'd2, 15'h0123);
        src.send(3'd3, 15'h0123);
        rd(axf_pkg::OFF_RESULT0, 32'hfffc);
        rd(axf_pkg::OFF_RESULT0 + 8'h04, 32'hfffc);
        rd(axf_pkg::OFF_RESULT0 + 8'h08, 32'h0);
        rd(axf_pkg::OFF_RESULT0 + 8'h0c, 32'h0);
        apb(1'b0, 8'h30, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, rd_err});
        apb(1'b0, 8'h41, 32'h0);
        chk("misaligned error", 32'h1, {31'h0, rd_err});
        // trip port 4, then release the detector before the rewrite
        src.set_ov(6'h10);
        repeat (4) @(posedge pclk);
        chk("disconnect", 32'h10, {26'h0, disc});
        rd(axf_pkg::OFF_DIAG_TWO, 32'h50);
        src.send(3'd4, 15'h0100);
        rd(axf_pkg::OFF_RESULT0 + 8'h10, 32'h0);
        src.set_ov(6'h00);
        repeat (4) @(posedge pclk);
        chk("disconnect held", 32'h10, {26'h0, disc});
        wr(axf_pkg::OFF_PORT_CFG, 32'h8);
        repeat (2) @(posedge pclk);
        chk("disconnect cleared", 32'h0, {26'h0, disc});
        rd(axf_pkg::OFF_DIAG_TWO, 32'h0);
        src.send(3'd4, 15'h0100);
        rd(axf_pkg::OFF_RESULT0 + 8'h10, 32'h400);
        wr(axf_pkg::OFF_BIAS_MODE, {30'h0, axf_pkg::BIAS_ON});
        repeat (2) @(posedge pclk);
        chk("bias on", 32'h1, {31'h0, bias});
        wr(axf_pkg::OFF_REF_CTRL, 32'h3f);
        wr(axf_pkg::OFF_BIAS_MODE, {30'h0, axf_pkg::BIAS_OFF});
        src.set_acq(1'b1);
        repeat (2) @(posedge pclk);
        chk("bias off", 32'h0, {31'h0, bias});
        for (int m = 0; m < 2; m++) begin
            wr(axf_pkg::OFF_BIAS_MODE, m);
            repeat (2) @(posedge pclk);
            chk("bias in acquisition", 32'h1, {31'h0, bias});
            src.set_acq(1'b0);
            repeat (3) @(posedge pclk);
            chk("bias idle", 32'h0, {31'h0, bias});
            src.set_acq(1'b1);
        end
        end_of_test;
    end

    initial begin
        #40000;
        error_cnt++;
        end_of_test;
    end
endmodule : test_aux_input_result_format
`default_nettype wire
